/* File: tb/mhbp_mem_model.sv */
// memory partner behind the port
module mhbp_mem_model (
    input  wire logic        clk,
    input  wire logic [16:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] store [256];
    always @(posedge clk) if (mem_wr) store[mem_addr[7:0]] <= mem_wdata;
    // idle read shows inverted data so a stale value cannot pass
    assign mem_rdata = mem_rd ? store[mem_addr[7:0]] : ~store[mem_addr[7:0]];
endmodule : mhbp_mem_model

/* File: tb/mhbp_port_bench.sv */
// self-checking bench for the host bus port
module mhbp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, als = 1'b0, c0 = 1'b1, c1 = 1'b1, c2 = 1'b1, pa0 = 1'b0;
    logic [7:0] ded = 8'h00, adin = 8'h00, bus, out, rdata, wdata, got;
    logic [16:0] addr, gaddr;
    logic oe, mrd, mwr, goe, rdn, wrn, grdn, gwrn, gmrd;
    int n_fail = 0, comparisons = 0;
    logic [16:0] ra [3] = '{17'h00012, 17'h10012, 17'h0A5FF};
    logic [7:0] rd [3] = '{8'hA5, 8'h5A, 8'h3C};
    logic re [3] = '{1'b1, 1'b0, 1'b1};
    logic [7:0] ew [3] = '{8'hA5, 8'hA5, 8'h3C};
    always #5 clk = ~clk;
    assign bus = oe ? out : adin;
    mhbp_port DUT (.clk(clk), .resetn(resetn), .address_latch_strobe(als),
        .control_input_0(c0), .control_input_1(c1), .control_input_2(c2),
        .port_a_bit0(pa0), .addr_dedicated(ded), .shared_addr_data_port_in(bus),
        .shared_addr_data_port_out(out), .shared_addr_data_port_oe(oe), .mem_addr(addr),
        .mem_rd(mrd), .mem_wr(mwr), .mem_wdata(wdata), .mem_rdata(rdata),
        .ext_rd_n(rdn), .ext_wr_n(wrn));
    mhbp_mem_model u_mem (.clk(clk), .mem_addr(addr), .mem_rd(mrd), .mem_wr(mwr),
        .mem_wdata(wdata), .mem_rdata(rdata));
    task chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: byte %h expected %h", $time, g, e);
        end
    endtask : chk8
    task chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask : chk1
    task chk17(input logic [16:0] g, input logic [16:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: address %h expected %h", $time, g, e);
        end
    endtask : chk17
    // host cycle: strobe phase, then data phase; f reads by the fetch strobe
    task cyc(input logic [16:0] a, input logic w, input logic [7:0] d, input logic f);
        @(negedge clk);
        als = 1'b1;
        pa0 = a[16];
        ded = a[15:8];
        adin = a[7:0];
        @(negedge clk);
        als = 1'b0;
        adin = w ? d : ~a[7:0];
        c0 = !w;
        c1 = w || f;
        c2 = w || !f;
        @(negedge clk);
        got = bus;
        goe = oe;
        gmrd = mrd;
        grdn = rdn;
        gwrn = wrn;
        gaddr = addr;
        c0 = 1'b1;
        c1 = 1'b1;
        c2 = 1'b1;
        repeat (3) @(negedge clk);
    endtask : cyc
    task final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        #20000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        chk1(mwr, 1'b0);
        for (int i = 0; i < 3; i++) begin
            cyc(ra[i], 1'b1, rd[i], 1'b0);
            chk1(goe, 1'b0);
            chk1(gwrn, 1'b0);
            chk17(gaddr, ra[i]);
            chk8(wdata, ew[i]);
            cyc(ra[i], 1'b0, 8'h00, 1'b0);
            chk1(goe, re[i]);
            chk1(gmrd, re[i]);
            chk1(grdn, 1'b0);
            if (re[i]) begin
                chk8(got, rd[i]);
            end else begin
                chk8(got, ~ra[i][7:0]);
            end
        end
        // program fetch strobe on input 2 reads the same store
        cyc(17'h0A5FF, 1'b0, 8'h00, 1'b1);
        chk1(goe, 1'b1);
        chk8(got, 8'h3C);
        // mid-run reset clears the latch and any write pulse
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk1(mwr, 1'b0);
        chk17(addr, 17'h0A500);
        // the unselected write must have left the first byte alone
        cyc(17'h00012, 1'b0, 8'h00, 1'b0);
        chk8(got, 8'hA5);
        final_report;
    end
endmodule : mhbp_port_bench

/* File: tb/mhbp_port_monitor.sv */
// assertion checker for the host bus port
module mhbp_port_monitor (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        address_latch_strobe,
    input wire logic        control_input_0,
    input wire logic        control_input_1,
    input wire logic        control_input_2,
    input wire logic        port_a_bit0,
    input wire logic [7:0]  shared_addr_data_port_in,
    input wire logic [7:0]  shared_addr_data_port_out,
    input wire logic        shared_addr_data_port_oe,
    input wire logic [16:0] mem_addr,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd_on = !(control_input_1 && control_input_2);
    a_oe_gate: assert property (shared_addr_data_port_oe == (!address_latch_strobe
        && !mem_addr[16] && rd_on)) else $error("bus drive wrong");
    a_out_data: assert property (shared_addr_data_port_oe |->
        shared_addr_data_port_out == mem_rdata) else $error("read data wrong");
    a_addr_latch: assert property (address_latch_strobe ##1 !address_latch_strobe |->
        mem_addr[7:0] == $past(shared_addr_data_port_in)
        && mem_addr[16] == $past(port_a_bit0)) else $error("latch wrong");
    a_addr_hold: assert property (!address_latch_strobe ##1 !address_latch_strobe |->
        $stable(mem_addr)) else $error("address moved");
    a_wr_pulse: assert property ($rose(control_input_0) && !mem_addr[16] |->
        ##[1:2] mem_wr) else $error("no write");
    a_wr_once: assert property (mem_wr |=> !mem_wr) else $error("long write");
    a_wr_cause: assert property ($rose(mem_wr) |-> !$past(control_input_0, 2)
        || !$past(control_input_0, 3)) else $error("stray write");
    a_wdata_hold: assert property (control_input_0 && $past(control_input_0) |=>
        $stable(mem_wdata)) else $error("data moved");
    cover property (shared_addr_data_port_oe);
    cover property (mem_wr);
    cover property (address_latch_strobe && port_a_bit0);
endmodule : mhbp_port_monitor
bind mhbp_port mhbp_port_monitor u_mon (.*);

/* File: verilog/mhbp_cfg.svh */
// constants of the 8-bit host bus port
`ifndef MHBP_CFG_SVH
`define MHBP_CFG_SVH
`define MHBP_ADDR_W      17
`define MHBP_DATA_W      8
`define MHBP_ADDR_RST    17'h00000
`define MHBP_WDATA_RST   8'h00
`define MHBP_BURST_LSB   0
`define MHBP_BURST_W     4
`define MHBP_SEL_BASE    17'h00000
`define MHBP_SEL_MASK    17'h10000
`endif

/* File: verilog/mhbp_pkg.sv */
// types of the 8-bit host bus port
package mhbp_pkg;
    typedef enum logic [2:0] {
        MHBP_CFG_NONPAGE_3STB = 3'h0,
        MHBP_CFG_NONPAGE_1RD  = 3'h1,
        MHBP_CFG_PAGE_1RD     = 3'h2,
        MHBP_CFG_PAGE_3STB    = 3'h3,
        MHBP_CFG_BURST        = 3'h4,
        MHBP_CFG_ENABLE_RW    = 3'h5
    } mhbp_cfg_t;
    typedef enum logic [1:0] {
        MHBP_IDLE  = 2'h0,
        MHBP_WRITE = 2'h1
    } mhbp_state_t;
endpackage : mhbp_pkg

/* File: verilog/mhbp_port.sv */
// host bus slave port for 8-bit multiplexed microcontroller buses
// What this block does
// - low address byte shares data lines; captured on address latch strobe
// - program fetch, read, write strobes enter control inputs 2, 1, 0
// - single read strobe configs: program fetch on input 1, write on 0
// - seventeenth address bit taken from port A bit 0
// - dual read page config: data read on input 1, fetch on input 2
// - page hit keeps latched upper address; only low byte changes
// - non-page mode latches the address every bus cycle
// - page cycles same timing; access timed from low address bits
// - four configurations: 1,2 non-page low mux; 3,4 page high mux
// - burst host: bits 3..0 dedicated, bits 11..4 on data lines
// - burst holds upper bits; host steps bits 3..0, up to 16 bytes
// - burst timing same; access timed from dedicated low bits
// - enable strobe plus read/write direction mode supported
// - decode array derives read and write strobes from enable and direction
// - control input functions fixed by stored configuration, not run-time
// - drive shared port only while selected and read strobe active
`include "mhbp_cfg.svh"
module mhbp_port #(
    parameter mhbp_pkg::mhbp_cfg_t CFG = mhbp_pkg::MHBP_CFG_NONPAGE_3STB
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       address_latch_strobe,
    input  wire logic                       control_input_0,
    input  wire logic                       control_input_1,
    input  wire logic                       control_input_2,
    input  wire logic                       port_a_bit0,
    input  wire logic [7:0]                 addr_dedicated,
    input  wire logic [`MHBP_DATA_W-1:0]    shared_addr_data_port_in,
    output logic      [`MHBP_DATA_W-1:0]    shared_addr_data_port_out,
    output logic                            shared_addr_data_port_oe,
    output logic      [`MHBP_ADDR_W-1:0]    mem_addr,
    output logic                            mem_rd,
    output logic                            mem_wr,
    output logic      [`MHBP_DATA_W-1:0]    mem_wdata,
    input  wire logic [`MHBP_DATA_W-1:0]    mem_rdata,
    output logic                            ext_rd_n,
    output logic                            ext_wr_n
);
    import mhbp_pkg::*;

    // latched address and its next value
    logic [`MHBP_ADDR_W-1:0] lat_r;
    logic [`MHBP_ADDR_W-1:0] lat_nxt;

    // write data captured during the active write strobe
    logic [`MHBP_DATA_W-1:0] wd_r;
    logic [`MHBP_DATA_W-1:0] wd_nxt;

    // write in progress and one-cycle commit pulse
    logic                    wr_r;
    logic                    wr_nxt;
    logic                    wrp_r;
    logic                    wrp_nxt;

    // decoded host strobes
    logic                    fetch_act;
    logic                    data_rd_act;
    logic                    rd_act;
    logic                    wr_act;

    // current address, its select and the qualified strobes
    logic [`MHBP_ADDR_W-1:0] addr;
    logic [`MHBP_ADDR_W-1:0] addr_masked;
    logic                    sel;
    logic                    sel_rd;
    logic                    wr_take;
    logic                    drive_bus;

    // strobe roles come from the parameter only, so no write can remap them
    always_comb begin
        fetch_act = 1'b0;
        data_rd_act = 1'b0;
        wr_act = 1'b0;
        case (CFG)
            MHBP_CFG_NONPAGE_3STB, MHBP_CFG_PAGE_3STB, MHBP_CFG_BURST: begin
                // fetch and data read both open the read path
                fetch_act = !control_input_2;
                data_rd_act = !control_input_1;
                wr_act = !control_input_0;
            end
            MHBP_CFG_NONPAGE_1RD, MHBP_CFG_PAGE_1RD: begin
                // the fetch strobe is the only read strobe and sits on input 1
                fetch_act = !control_input_1;
                data_rd_act = 1'b0;
                wr_act = !control_input_0;
            end
            MHBP_CFG_ENABLE_RW: begin
                // input 0 is direction (high = read), input 1 is enable (high)
                fetch_act = 1'b0;
                data_rd_act = control_input_1 && control_input_0;
                wr_act = control_input_1 && !control_input_0;
            end
            default: begin
                fetch_act = 1'b0;
                data_rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
    end

    // either read strobe may reach memory or ports
    assign rd_act = fetch_act || data_rd_act;

    // latch follows the strobe; holding it keeps the upper part for page hits
    always_comb begin
        lat_nxt = lat_r;
        if (address_latch_strobe) begin
            case (CFG)
                MHBP_CFG_PAGE_1RD, MHBP_CFG_PAGE_3STB: begin
                    lat_nxt[15:8] = shared_addr_data_port_in;
                end
                MHBP_CFG_BURST: begin
                    lat_nxt[11:4] = shared_addr_data_port_in;
                    lat_nxt[15:12] = addr_dedicated[7:4];
                end
                default: begin
                    lat_nxt[7:0] = shared_addr_data_port_in;
                end
            endcase
            lat_nxt[16] = port_a_bit0;
        end
    end

    // low bits live, no dependence on strobe setup or hold in page and burst
    always_comb begin
        addr = lat_r;
        case (CFG)
            MHBP_CFG_PAGE_1RD, MHBP_CFG_PAGE_3STB: begin
                addr[7:0] = addr_dedicated;
            end
            MHBP_CFG_BURST: begin
                addr[`MHBP_BURST_W-1:`MHBP_BURST_LSB] = addr_dedicated[3:0];
            end
            default: begin
                addr[15:8] = addr_dedicated;
            end
        endcase
        if (address_latch_strobe) begin
            addr = lat_nxt;
        end
    end

    // select decode on address bit 16 only, through the select mask
    assign addr_masked = addr & `MHBP_SEL_MASK;
    assign sel = (addr_masked == `MHBP_SEL_BASE);

    // a strobe counts only while the address decodes to this device
    assign wr_take = wr_act && sel;
    assign sel_rd = rd_act && sel;
    // no drive over the latch phase, the host still owns the lines then
    assign drive_bus = sel_rd && !address_latch_strobe;

    // write data is taken at every edge of an active, selected write strobe
    always_comb begin
        wd_nxt = wd_r;
        if (wr_take) begin
            wd_nxt = shared_addr_data_port_in;
        end
    end

    // the commit pulse follows the edge at which the write strobe has gone
    always_comb begin
        wr_nxt = wr_r;
        wrp_nxt = 1'b0;
        if (wr_take) begin
            wr_nxt = 1'b1;
        end else if (wr_r) begin
            // committing late keeps the data stable for the whole strobe
            wr_nxt = 1'b0;
            wrp_nxt = 1'b1;
        end
    end

    // latch group
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lat_r <= `MHBP_ADDR_RST;
        end else begin
            lat_r <= lat_nxt;
        end
    end

    // write data group
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wd_r <= `MHBP_WDATA_RST;
        end else begin
            wd_r <= wd_nxt;
        end
    end

    // write pulse group
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_r <= 1'b0;
            wrp_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            wrp_r <= wrp_nxt;
        end
    end

    // memory side
    assign mem_addr = addr;
    assign mem_rd = sel_rd;
    // write pulse is registered so memory sees one clean cycle
    assign mem_wr = wrp_r;
    assign mem_wdata = wd_r;

    // read data goes out only on a selected read
    assign shared_addr_data_port_out = mem_rdata;
    assign shared_addr_data_port_oe = drive_bus;

    // separate strobes for external parts, handy for enable/direction hosts
    assign ext_rd_n = !rd_act;
    assign ext_wr_n = !wr_act;
endmodule : mhbp_port
